// ===== rtl/bdc_pkg.sv
// How it works
// - secured special reset overlays secure table; erased memories set unsecure flag.
// - failed erase check sets enable flag only; firmware commands stay locked.
// - after secure run, eeprom map and program page regs leave reset values.
// - firmware commands only while active; activation only once enable flag set.
// - enter command, tagging, halt instruction or breakpoint force/tag activate.
// - cpu finishes current instruction, then runs standard firmware table.
// - breakpoint type picks activation before or after next instruction.
// - special single-chip reset leaves debug enabled and active at once.
// - activation while disabled delays cpu briefly; enter command ignored, no delay.
// - active mode maps registers and table at FF00-FFFF, registers FF00-FF07.
// - debug unit reads registers anytime; user program reads are blocked.
// - hardware commands run anytime and wait for a free cpu bus cycle.
// - no free cycle within 128 clocks freezes cpu to steal one.
// - single-cycle access in a free cycle never freezes; multi-cycle access freezes until done.
// - opcode 90 enters active mode if enabled; handshake pulse on entry.
// - D5 enables handshake with pulse; D6 disables it without pulse.
// - reads E4/EC debug space, E0/E8 normal; 16-bit address, 16 data out.
// - writes C4/CC debug space, C0/C8 normal; 16-bit address, 16 data in.
// - debug-space variants enable debug resources for that access cycle only.
// - byte data odd address low byte, even high byte; words force alignment.
// - handshake pulse when read data ready, or when write has finished.
// - command is 8-bit opcode, then 16-bit address and/or 16-bit data.
package bdc_pkg;
	// ------------------------------------------------------------
	// opcodes and opcode fields
	// ------------------------------------------------------------
	localparam logic [7:0] OP_ENTER_DEBUG = 8'h90;
	localparam logic [7:0] OP_ACK_ON = 8'hD5;
	localparam logic [7:0] OP_ACK_OFF = 8'hD6;
	localparam int OP_BIT_READ = 5;
	localparam int OP_BIT_WORD = 3;
	localparam int OP_BIT_DBG = 2;
	// ------------------------------------------------------------
	// debug window and status register
	// ------------------------------------------------------------
	localparam logic [7:0] DBG_WIN_PAGE = 8'hFF;
	localparam logic [15:0] DBG_REG_FIRST = 16'hFF00;
	localparam logic [15:0] DBG_REG_LAST = 16'hFF07;
	localparam logic [15:0] DBG_STATUS_ADDR = 16'hFF01;
	localparam int DBG_STATUS_EN_BIT = 7;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int STEAL_WAIT_CYC = 128;
	localparam int HOST_WAIT_CYC = 150;
	// ------------------------------------------------------------
	// apb map
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL_OFS = 12'h000;
	localparam logic [11:0] REG_STATUS_OFS = 12'h004;
	localparam logic [7:0] CTRL_RESUME_DLY_RST = 8'h08;
	localparam int ST_EN_BIT = 0;
	localparam int ST_UNSECURE_FLAG_BIT = 1;
	localparam int ST_ACTIVE_BIT = 2;
	localparam int ST_ACK_BIT = 3;
	localparam int ST_OVERLAY_BIT = 4;
	localparam int ST_MOVED_BIT = 5;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		CS_IDLE = 7'b000_0001,
		CS_ADDR_HI = 7'b000_0010,
		CS_ADDR_LO = 7'b000_0100,
		CS_DATA_HI = 7'b000_1000,
		CS_DATA_LO = 7'b001_0000,
		CS_WAIT_BUS = 7'b010_0000,
		CS_ACCESS = 7'b100_0000
	} bdc_cmd_e;
	typedef enum logic [4:0] {
		AS_OFF = 5'b0_0001,
		AS_PEND = 5'b0_0010,
		AS_PEND2 = 5'b0_0100,
		AS_ON = 5'b0_1000,
		AS_REFUSE = 5'b1_0000
	} bdc_act_e;
	typedef struct packed {
		logic valid;
		logic write;
		logic dbg_space;
		logic [1:0] lane;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bdc_mem_req_s;
endpackage : bdc_pkg

// ===== rtl/bdc_cmd_unit.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bdc_cmd_unit (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// serial byte layer
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic fw_busy_i,
	output logic tx_valid_o,
	output logic [15:0] tx_word_o,
	output logic ack_pulse_o,
	output logic fw_cmd_valid_o,
	output logic [7:0] fw_cmd_o,
	// cpu bus
	input wire logic cpu_free_i,
	input wire logic mem_ack_i,
	input wire logic [15:0] mem_rdata_i,
	output bdc_pkg::bdc_mem_req_s mem_req_o,
	output logic cpu_freeze_o,
	// activation
	input wire logic tag_hit_i,
	input wire logic halt_instr_i,
	input wire logic brk_force_i,
	input wire logic brk_tag_i,
	input wire logic instr_done_i,
	input wire logic fw_exit_i,
	output logic debug_active_o,
	output logic cpu_hold_o,
	output logic dbg_map_o,
	// secure boot
	input wire logic special_sc_i,
	input wire logic secured_i,
	input wire logic erase_done_i,
	input wire logic erase_ok_i,
	output logic secure_overlay_o,
	output logic init_regs_moved_o,
	// user read guard
	input wire logic user_rd_i,
	input wire logic [15:0] user_addr_i,
	output logic user_rd_block_o
);
	import bdc_pkg::*;

	// ------------------------------------------------------------
	// flags and boot
	// ------------------------------------------------------------
	logic boot_q, enable_q, unsecure_flag_q, overlay_q, moved_q, ack_en_q;
	logic [7:0] resume_dly_q;
	bdc_cmd_e cs_q;
	bdc_act_e as_q;
	logic [7:0] op_q;
	logic [15:0] addr_q, data_q;
	logic [7:0] wait_cnt_q, dly_cnt_q;
	logic steal_q, first_q, by_cmd_q;
	logic is_rd, is_word, is_dbg, op_mem, rx_op, enter_cmd, acc_done, st_write;

	assign rx_op = rx_valid_i && !fw_busy_i && cs_q == CS_IDLE;
	assign op_mem = rx_byte_i[7:6] == 2'b11 && !rx_byte_i[4] && rx_byte_i[1:0] == 2'b00;
	assign enter_cmd = rx_op && rx_byte_i == OP_ENTER_DEBUG;
	assign is_rd = op_q[OP_BIT_READ];
	assign is_word = op_q[OP_BIT_WORD];
	assign is_dbg = op_q[OP_BIT_DBG];
	assign acc_done = cs_q == CS_ACCESS && mem_ack_i;
	// host write of the enable bit through debug space
	assign st_write = acc_done && !is_rd && is_dbg && mem_req_o.lane[0]
		&& {mem_req_o.addr[15:1], 1'b1} == DBG_STATUS_ADDR;

	// strap is caught on the first clocked edge after release
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			enable_q <= 1'b0;
		end else if (boot_q && special_sc_i) begin
			enable_q <= 1'b1;
		end else if (erase_done_i && overlay_q && !erase_ok_i) begin
			enable_q <= 1'b1;
		end else if (st_write) begin
			enable_q <= data_q[DBG_STATUS_EN_BIT];
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			overlay_q <= 1'b0;
			unsecure_flag_q <= 1'b0;
			moved_q <= 1'b0;
		end else if (boot_q) begin
			overlay_q <= special_sc_i && secured_i;
		end else if (erase_done_i && overlay_q) begin
			moved_q <= 1'b1;
			if (erase_ok_i) begin
				unsecure_flag_q <= 1'b1;
				overlay_q <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// activation
	// ------------------------------------------------------------
	logic act_src;
	assign act_src = tag_hit_i || halt_instr_i || brk_force_i || brk_tag_i;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			as_q <= AS_OFF;
			by_cmd_q <= 1'b0;
			dly_cnt_q <= 8'h00;
		end else begin
			unique case (as_q)
				AS_OFF: begin
					if (boot_q && special_sc_i) begin
						as_q <= AS_ON;
						by_cmd_q <= 1'b0;
					end else if (enable_q && (act_src || enter_cmd)) begin
						as_q <= brk_tag_i ? AS_PEND2 : AS_PEND;
						by_cmd_q <= enter_cmd;
					end else if (!enable_q && act_src) begin
						as_q <= AS_REFUSE;
						dly_cnt_q <= resume_dly_q;
					end
				end
				AS_PEND2: if (instr_done_i) as_q <= AS_PEND;
				AS_PEND: if (instr_done_i) as_q <= AS_ON;
				AS_ON: if (fw_exit_i) as_q <= AS_OFF;
				AS_REFUSE: begin
					if (dly_cnt_q == 8'h00) begin
						as_q <= AS_OFF;
					end else begin
						dly_cnt_q <= dly_cnt_q - 8'h01;
					end
				end
			endcase
		end
	end

	assign debug_active_o = as_q == AS_ON;
	assign cpu_hold_o = as_q == AS_REFUSE;
	assign secure_overlay_o = overlay_q;
	assign init_regs_moved_o = moved_q;
	// debug resources only while active or for a debug-space cycle
	assign dbg_map_o = debug_active_o || (mem_req_o.valid && mem_req_o.dbg_space);
	// user programs never see the debug registers
	assign user_rd_block_o = user_rd_i && user_addr_i >= DBG_REG_FIRST
		&& user_addr_i <= DBG_REG_LAST;

	// ------------------------------------------------------------
	// command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cs_q <= CS_IDLE;
			op_q <= 8'h00;
			addr_q <= 16'h0000;
			data_q <= 16'h0000;
			wait_cnt_q <= 8'h00;
			steal_q <= 1'b0;
			first_q <= 1'b0;
		end else begin
			unique case (cs_q)
				CS_IDLE: begin
					if (rx_op && op_mem) begin
						op_q <= rx_byte_i;
						cs_q <= CS_ADDR_HI;
					end
				end
				CS_ADDR_HI: if (rx_valid_i) begin
					addr_q[15:8] <= rx_byte_i;
					cs_q <= CS_ADDR_LO;
				end
				CS_ADDR_LO: if (rx_valid_i) begin
					addr_q[7:0] <= rx_byte_i;
					cs_q <= is_rd ? CS_WAIT_BUS : CS_DATA_HI;
					wait_cnt_q <= 8'h00;
				end
				CS_DATA_HI: if (rx_valid_i) begin
					data_q[15:8] <= rx_byte_i;
					cs_q <= CS_DATA_LO;
				end
				CS_DATA_LO: if (rx_valid_i) begin
					data_q[7:0] <= rx_byte_i;
					cs_q <= CS_WAIT_BUS;
					wait_cnt_q <= 8'h00;
				end
				CS_WAIT_BUS: begin
					if (cpu_free_i) begin
						cs_q <= CS_ACCESS;
						steal_q <= 1'b0;
						first_q <= 1'b1;
					end else if (wait_cnt_q == 8'(STEAL_WAIT_CYC - 1)) begin
						cs_q <= CS_ACCESS;
						steal_q <= 1'b1;
						first_q <= 1'b1;
					end else begin
						wait_cnt_q <= wait_cnt_q + 8'h01;
					end
				end
				CS_ACCESS: begin
					first_q <= 1'b0;
					if (mem_ack_i) begin
						cs_q <= CS_IDLE;
						if (is_rd) data_q <= mem_rdata_i;
					end
				end
				default: cs_q <= CS_IDLE;
			endcase
		end
	end

	always_comb begin
		mem_req_o = '0;
		mem_req_o.valid = cs_q == CS_ACCESS;
		mem_req_o.write = !is_rd;
		mem_req_o.dbg_space = is_dbg;
		mem_req_o.addr = is_word ? {addr_q[15:1], 1'b0} : addr_q;
		mem_req_o.lane = is_word ? 2'b11 : (addr_q[0] ? 2'b01 : 2'b10);
		mem_req_o.wdata = data_q;
	end

	// a free cycle is not intruded on unless the access runs past it
	assign cpu_freeze_o = cs_q == CS_ACCESS && (steal_q || !first_q);

	// ------------------------------------------------------------
	// answers to the serial layer
	// ------------------------------------------------------------
	logic [15:0] rd_lane;
	always_comb begin
		rd_lane = mem_rdata_i;
		if (!is_word) begin
			rd_lane = addr_q[0] ? {8'h00, mem_rdata_i[7:0]} : {mem_rdata_i[15:8], 8'h00};
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_en_q <= 1'b0;
		end else if (rx_op && rx_byte_i == OP_ACK_ON) begin
			ack_en_q <= 1'b1;
		end else if (rx_op && rx_byte_i == OP_ACK_OFF) begin
			ack_en_q <= 1'b0;
		end
	end

	// pulse shape is stretched by the serial layer
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_valid_o <= 1'b0;
			tx_word_o <= 16'h0000;
			ack_pulse_o <= 1'b0;
			fw_cmd_valid_o <= 1'b0;
			fw_cmd_o <= 8'h00;
		end else begin
			tx_valid_o <= acc_done && is_rd;
			if (acc_done && is_rd) tx_word_o <= rd_lane;
			// a disable arriving with a due pulse wins, so no pulse follows it
			ack_pulse_o <= ack_en_q && !(rx_op && rx_byte_i == OP_ACK_OFF) && (acc_done
				|| (as_q == AS_PEND && instr_done_i && by_cmd_q))
				|| (rx_op && rx_byte_i == OP_ACK_ON);
			fw_cmd_valid_o <= rx_op && !op_mem && rx_byte_i != OP_ENTER_DEBUG
				&& rx_byte_i != OP_ACK_ON && rx_byte_i != OP_ACK_OFF
				&& debug_active_o && !overlay_q;
			if (rx_op) fw_cmd_o <= rx_byte_i;
		end
	end

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic apb_wr, apb_hit;
	assign apb_hit = paddr_i == REG_CTRL_OFS || paddr_i == REG_STATUS_OFS;
	assign apb_wr = psel_i && penable_i && pwrite_i && paddr_i == REG_CTRL_OFS;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !apb_hit;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			resume_dly_q <= CTRL_RESUME_DLY_RST;
		end else if (apb_wr) begin
			resume_dly_q <= pwdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i) begin
			prdata_o <= 32'h0000_0000;
			if (paddr_i == REG_CTRL_OFS) prdata_o[7:0] <= resume_dly_q;
			if (paddr_i == REG_STATUS_OFS) begin
				prdata_o[ST_EN_BIT] <= enable_q;
				prdata_o[ST_UNSECURE_FLAG_BIT] <= unsecure_flag_q;
				prdata_o[ST_ACTIVE_BIT] <= debug_active_o;
				prdata_o[ST_ACK_BIT] <= ack_en_q;
				prdata_o[ST_OVERLAY_BIT] <= overlay_q;
				prdata_o[ST_MOVED_BIT] <= moved_q;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	a_fw_cmd_gate: assert property (fw_cmd_valid_o |-> $past(debug_active_o) && !$past(overlay_q))
		else $error("firmware command passed while not allowed");
	a_active_needs_en: assert property ($rose(debug_active_o) && !$past(boot_q) |-> enable_q)
		else $error("debug became active without enable");
	a_steal_bound: assert property (cs_q == CS_WAIT_BUS && wait_cnt_q == 8'(STEAL_WAIT_CYC - 1)
		&& !cpu_free_i
		|=> cs_q == CS_ACCESS && cpu_freeze_o)
		else $error("cycle not stolen after wait limit");
	a_free_no_freeze: assert property ($rose(cs_q == CS_ACCESS) && !steal_q |-> !cpu_freeze_o)
		else $error("free cycle access froze the cpu");
	a_multi_freeze: assert property (cs_q == CS_ACCESS && !mem_ack_i |=> cpu_freeze_o)
		else $error("multi cycle access left cpu running");
	a_byte_lane: assert property (acc_done && is_rd && !is_word && addr_q[0]
		|=> tx_valid_o && tx_word_o[15:8] == 8'h00)
		else $error("odd byte read not on low lane");
	a_read_ack: assert property (acc_done && is_rd && ack_en_q |=> tx_valid_o && ack_pulse_o)
		else $error("read data ready without handshake");
	a_ack_off_quiet: assert property (rx_op && rx_byte_i == OP_ACK_OFF |=> !ack_pulse_o && !ack_en_q)
		else $error("handshake disable emitted a pulse");
	a_enter_ignored: assert property (as_q == AS_OFF && !enable_q && enter_cmd && !act_src
		|=> as_q == AS_OFF ##1 !cpu_hold_o)
		else $error("enter command acted while disabled");
	a_dbg_map_cycle: assert property (mem_req_o.valid && mem_req_o.dbg_space |-> dbg_map_o)
		else $error("debug space access without debug map");
	a_user_block: assert property (user_rd_i && user_addr_i == DBG_STATUS_ADDR |-> user_rd_block_o)
		else $error("user read of debug register not blocked");

	c_steal: cover property (cs_q == CS_WAIT_BUS ##1 cs_q == CS_ACCESS && steal_q);
	c_brk_tag: cover property (as_q == AS_PEND2 ##[1:20] as_q == AS_ON);
	c_secure_fail: cover property (overlay_q && erase_done_i && !erase_ok_i);
	c_refuse: cover property (as_q == AS_REFUSE ##[1:300] as_q == AS_OFF);
endmodule : bdc_cmd_unit
`default_nettype wire

// ===== dv/bdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_host_model (
	// clock
	input wire logic clock_i,
	// byte stream toward the unit
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o
);
	import bdc_pkg::*;
	int gap_cyc = 0;
	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
	end
	// ------------------------------------------------------------
	// byte transmit
	// ------------------------------------------------------------
	// idle lane shows the inverse of the last byte so stale data never looks valid
	// the gap leads each byte so the caller regains control right after the last byte
	task automatic send_byte(input logic [7:0] b);
		repeat (gap_cyc) @(posedge clock_i);
		@(posedge clock_i);
		rx_valid_o <= 1'b1;
		rx_byte_o <= b;
		@(posedge clock_i);
		rx_valid_o <= 1'b0;
		rx_byte_o <= ~b;
	endtask : send_byte
	// opcode, then address hi/lo, then data hi/lo as the command needs
	task automatic send_cmd(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
		input int nbytes);
		send_byte(op);
		if (nbytes > 1) begin
			send_byte(a[15:8]);
			send_byte(a[7:0]);
		end
		if (nbytes > 3) begin
			send_byte(d[15:8]);
			send_byte(d[7:0]);
		end
	endtask : send_cmd
	// without handshake the host idles before fetching data or sending more
	task automatic turnaround();
		repeat (HOST_WAIT_CYC) @(posedge clock_i);
	endtask : turnaround
endmodule : bdc_host_model
`default_nettype wire

// ===== dv/bdc_cmd_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_cmd_unit_tb;
	import bdc_pkg::*;
	logic clock_i, sys_rst_i, psel, penable, pwrite, rx_valid, fw_busy, cpu_free, mem_ack;
	logic tag_hit, halt_instr, brk_force, brk_tag, instr_done, fw_exit, special_sc, secured;
	logic erase_done, erase_ok, user_rd, pready, pslverr, tx_valid, ack_pulse, fw_cmd_valid;
	logic cpu_freeze, debug_active, cpu_hold, dbg_map, overlay, moved, rd_block, ack_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [7:0] rx_byte, fw_cmd;
	logic [15:0] mem_rdata, tx_word, user_addr;
	logic er;
	bdc_mem_req_s mem_req;
	int miscompares = 0;
	int checks_done = 0;
	bdc_cmd_unit dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rx_valid_i(rx_valid),
		.rx_byte_i(rx_byte), .fw_busy_i(fw_busy), .tx_valid_o(tx_valid), .tx_word_o(tx_word),
		.ack_pulse_o(ack_pulse), .fw_cmd_valid_o(fw_cmd_valid), .fw_cmd_o(fw_cmd),
		.cpu_free_i(cpu_free), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
		.mem_req_o(mem_req), .cpu_freeze_o(cpu_freeze), .tag_hit_i(tag_hit),
		.halt_instr_i(halt_instr), .brk_force_i(brk_force), .brk_tag_i(brk_tag),
		.instr_done_i(instr_done), .fw_exit_i(fw_exit), .debug_active_o(debug_active),
		.cpu_hold_o(cpu_hold), .dbg_map_o(dbg_map), .special_sc_i(special_sc),
		.secured_i(secured), .erase_done_i(erase_done), .erase_ok_i(erase_ok),
		.secure_overlay_o(overlay), .init_regs_moved_o(moved), .user_rd_i(user_rd),
		.user_addr_i(user_addr), .user_rd_block_o(rd_block));
	bdc_host_model host_u (.clock_i(clock_i), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte));
	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run
	task automatic do_reset(input logic sc, input logic sec);
		sys_rst_i <= 1'b1;
		special_sc <= sc;
		secured <= sec;
		repeat (16) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clock_i);
	endtask : do_reset
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		rv = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one hardware memory command from opcode to handshake
	task automatic hw_op(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
		input logic [15:0] rd, input logic steal);
		int n;
		logic wr, w;
		logic [1:0] lane;
		logic [15:0] ea, etx;
		wr = ~op[OP_BIT_READ];
		w = op[OP_BIT_WORD];
		ea = w ? {a[15:1], 1'b0} : a;
		lane = w ? 2'b11 : (a[0] ? 2'b01 : 2'b10);
		etx = w ? rd : (a[0] ? {8'h00, rd[7:0]} : {rd[15:8], 8'h00});
		cpu_free <= ~steal;
		host_u.send_cmd(op, a, d, wr ? 5 : 3);
		for (n = 0; n < 300; n++) begin
			@(posedge clock_i);
			if (mem_req.valid === 1'b1) break;
		end
		if (steal) chk("steal_wait", 32'h1, 32'(n >= 128 && n <= 131));
		else chk("free_wait", 32'h1, 32'(n <= 3));
		chk("freeze", {31'h0, steal}, {31'h0, cpu_freeze});
		chk("mem_req", {12'h0, wr, op[OP_BIT_DBG], lane, ea}, {12'h0, mem_req.write,
			mem_req.dbg_space, mem_req.lane, mem_req.addr});
		if (wr) chk("wdata", {16'h0, d}, {16'h0, mem_req.wdata});
		mem_ack <= 1'b1;
		mem_rdata <= rd;
		@(posedge clock_i);
		mem_ack <= 1'b0;
		mem_rdata <= ~rd;
		cpu_free <= 1'b1;
		@(posedge clock_i);
		chk("tx_valid", {31'h0, ~wr}, {31'h0, tx_valid});
		if (!wr) chk("tx_word", {16'h0, etx}, {16'h0, tx_word});
		chk("ack", {31'h0, ack_on}, {31'h0, ack_pulse});
	endtask : hw_op
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		apb(1'b0, REG_CTRL_OFS, 32'h0);
		chk("ctrl_rst", {24'h0, CTRL_RESUME_DLY_RST}, rv);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		chk("status_rst", 32'h0, rv);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		chk("unmapped_err", 32'h1, {31'h0, er});
	endtask : t_regs
	task automatic t_refuse();
		host_u.send_cmd(OP_ENTER_DEBUG, 16'h0, 16'h0, 1);
		repeat (2) @(posedge clock_i);
		chk("enter_off", 32'h0, {30'h0, debug_active, cpu_hold});
		halt_instr <= 1'b1;
		@(posedge clock_i);
		halt_instr <= 1'b0;
		@(posedge clock_i);
		chk("hold_on", 32'h1, {31'h0, cpu_hold});
		repeat (12) @(posedge clock_i);
		chk("hold_off", 32'h0, {30'h0, debug_active, cpu_hold});
	endtask : t_refuse
	task automatic t_rw();
		host_u.send_cmd(OP_ACK_ON, 16'h0, 16'h0, 1);
		@(posedge clock_i);
		ack_on = 1'b1;
		chk("ack_on", 32'h1, {31'h0, ack_pulse});
		host_u.gap_cyc = 3;
		for (int i = 0; i < 4; i++) hw_op(8'hE0 | 8'(i << 2), 16'h1234 + 16'(i), 16'h0,
			16'hAB5C, 1'b0);
		for (int i = 0; i < 4; i++) hw_op(8'hC0 | 8'(i << 2), 16'h2001 + 16'(i), 16'hA53C,
			16'h0, 1'b0);
		host_u.gap_cyc = 0;
		hw_op(8'hC4, DBG_STATUS_ADDR, 16'h0080, 16'h0, 1'b0);
		apb(1'b0, REG_STATUS_OFS, 32'h0);
		chk("enable_set", 32'h1, {31'h0, rv[ST_EN_BIT]});
		host_u.send_cmd(OP_ACK_OFF, 16'h0, 16'h0, 1);
		@(posedge clock_i);
		ack_on = 1'b0;
		chk("ack_off", 32'h0, {31'h0, ack_pulse});
		hw_op(8'hE8, 16'h4001, 16'h0, 16'h1357, 1'b1);
		host_u.turnaround();
	endtask : t_rw
	task automatic t_enter();
		host_u.send_cmd(OP_ACK_ON, 16'h0, 16'h0, 1);
		host_u.send_cmd(OP_ENTER_DEBUG, 16'h0, 16'h0, 1);
		instr_done <= 1'b1;
		@(posedge clock_i);
		instr_done <= 1'b0;
		@(posedge clock_i);
		chk("entered", 32'h7, {29'h0, debug_active, dbg_map, ack_pulse});
		host_u.send_cmd(8'h64, 16'h0, 16'h0, 1);
		@(posedge clock_i);
		chk("fw_cmd", {23'h0, 1'b1, 8'h64}, {23'h0, fw_cmd_valid, fw_cmd});
		user_rd <= 1'b1;
		user_addr <= DBG_REG_LAST;
		@(posedge clock_i);
		chk("user_block", 32'h1, {31'h0, rd_block});
		user_addr <= DBG_REG_LAST + 16'h1;
		@(posedge clock_i);
		chk("user_pass", 32'h0, {31'h0, rd_block});
		user_rd <= 1'b0;
		fw_exit <= 1'b1;
		@(posedge clock_i);
		fw_exit <= 1'b0;
		brk_tag <= 1'b1;
		@(posedge clock_i);
		brk_tag <= 1'b0;
		instr_done <= 1'b1;
		repeat (2) @(posedge clock_i);
		chk("brk_late", 32'h0, {31'h0, debug_active});
		instr_done <= 1'b0;
		@(posedge clock_i);
		chk("brk_active", 32'h1, {31'h0, debug_active});
	endtask : t_enter
	// first pass fails the erase check, second pass passes it
	task automatic t_secure();
		for (int k = 0; k < 2; k++) begin
			do_reset(1'b1, 1'b1);
			chk("boot_active", 32'h3, {30'h0, debug_active, overlay});
			erase_ok <= k[0];
			erase_done <= 1'b1;
			@(posedge clock_i);
			erase_done <= 1'b0;
			repeat (2) @(posedge clock_i);
			chk("regs_moved", 32'h1, {31'h0, moved});
			host_u.send_cmd(8'h64, 16'h0, 16'h0, 1);
			@(posedge clock_i);
			chk("fw_gate", {31'h0, k[0]}, {31'h0, fw_cmd_valid});
			apb(1'b0, REG_STATUS_OFS, 32'h0);
			chk("unsecured", {30'h0, k[0], 1'b1}, {30'h0, rv[ST_UNSECURE_FLAG_BIT], rv[ST_EN_BIT]});
		end
	endtask : t_secure
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, fw_busy, mem_ack, tag_hit, halt_instr, brk_force} = '0;
		{brk_tag, instr_done, fw_exit, special_sc, secured, erase_done, erase_ok} = '0;
		{user_rd, ack_on} = '0;
		{paddr, pwdata, mem_rdata, user_addr} = '0;
		sys_rst_i = 1'b1;
		cpu_free = 1'b1;
		do_reset(1'b0, 1'b0);
		t_regs();
		t_refuse();
		t_rw();
		t_enter();
		t_secure();
		complete_run();
	end
	initial begin
		#(5ns * 20000);
		miscompares++;
		complete_run();
	end
endmodule : bdc_cmd_unit_tb
`default_nettype wire
